/* File: pkg/fsfc_defs.svh */
`ifndef FSFC_DEFS_SVH
`define FSFC_DEFS_SVH

// register byte offsets
`define FSFC_OFS_FEATURE_ZERO  4'h0
`define FSFC_OFS_EXC_CTRL      4'h4
`define FSFC_OFS_ACCESS_CTRL   4'h8
`define FSFC_OFS_STATUS        4'hC

// feature register fields
`define FSFC_FEAT_ROUND        4'h1
`define FSFC_FEAT_SHORT_VEC    4'h0
`define FSFC_FEAT_SQRT         4'h1
`define FSFC_FEAT_DIVIDE       4'h1
`define FSFC_FEAT_TRAP         4'h0
`define FSFC_FEAT_DOUBLE       4'h2
`define FSFC_FEAT_SINGLE       4'h2
`define FSFC_FEAT_BANK         4'h2

// exception/control register fields
`define FSFC_EXC_ASYNC_BIT     31
`define FSFC_EXC_ENABLE_BIT    30
`define FSFC_EXC_UNK_MSB       25

// access control register fields
`define FSFC_ACC_PRIV_BIT      0
`define FSFC_ACC_SECURE_BIT    1
`define FSFC_ACC_COPROC_BIT    2
`define FSFC_ACC_TEN_BIT       3
`define FSFC_ACC_ELEVEN_BIT    4
`define FSFC_ACC_HYP_TRAP_BIT  5
`define FSFC_ACC_STRIDE_LSB    8
`define FSFC_ACC_STRIDE_MSB    10

// status register fields
`define FSFC_ST_DENIED_BIT     0
`define FSFC_ST_UNIT_EN_BIT    1
`define FSFC_ST_UNDEF_BIT      2

`define FSFC_RESET_WORD        32'h0000_0000
`define FSFC_ERR_WORD          32'hDEAD_0000

`endif

/* File: pkg/fsfc_pkg.sv */
package fsfc_pkg;

  typedef enum logic [1:0]
  {
    FSFC_IDLE = 2'b00,
    FSFC_ANSW = 2'b01
  } fsfc_state_t;

  typedef struct packed
  {
    fsfc_state_t state;
    logic        waitreq;
    logic [31:0] rdata;
    logic        resp_err;
    logic [25:0] exc_unk;
    logic        unit_en;
    logic [10:0] access;
    logic        denied;
    logic        undef_seen;
  } fsfc_regs_t;

endpackage : fsfc_pkg

/* File: rtl/fsfc_access_gate.sv */
`timescale 1ns/1ps
`include "fsfc_defs.svh"

// decides whether a register access may proceed
module fsfc_access_gate
  import fsfc_pkg::*;
(
  // access context
  input  wire logic        privileged,
  input  wire logic        secure,
  input  wire logic        coproc_access_ctrl,
  input  wire logic        coproc_ten_grant,
  input  wire logic        coproc_eleven_grant,
  input  wire logic        hyp_coproc_trap,
  input  wire logic        is_exc_ctrl,
  // result
  output logic             permit
);

  logic nonsecure_ok;

  always_comb
  begin
    nonsecure_ok = coproc_ten_grant && coproc_eleven_grant
                   && !hyp_coproc_trap;
    permit = privileged
             && (secure || nonsecure_ok)
             && (!is_exc_ctrl || coproc_access_ctrl);
  end

endmodule : fsfc_access_gate

/* File: rtl/fsfc_regs.sv */
`timescale 1ns/1ps
`include "fsfc_defs.svh"

// Summary of operation
// - feature bits 31:28 read 1, all rounding modes supported.
// - feature bits 27:24 read 0, short vectors unsupported.
// - feature bits 23:20 and 19:16 read 1, square root and divide.
// - feature bits 15:12 read 0, no exception trapping.
// - feature bits 11:8 and 7:4 read 2, double and single precision.
// - feature bits 3:0 read 2, thirty-two 64-bit bank registers.
// - only privileged accesses to the feature and control registers are accepted.
// - nonsecure access needs both coprocessor ten and eleven grants.
// - nonsecure access is also gated by the hypervisor trap.
// - control register access needs the coprocessor access permission.
// - the feature and control registers exist only when the float unit is implemented.
// - control bit 31 reads zero and ignores writes.
// - control bit 30 is the global enable of the float and vector units.
// - the global enable clears on reset.
// - nonzero vector stride makes non-compare, non-convert ops undefined.
module fsfc_regs
  import fsfc_pkg::*;
#(
  parameter bit FLOAT_PRESENT = 1'b1
)
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // avalon-mm slave
  input  wire logic [3:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  output logic [1:0]       response,
  // instruction classification
  input  wire logic        float_dp_op,
  input  wire logic        float_cmp_cvt,
  // unit control
  output logic             float_unit_enable,
  output logic             undef_instr
);

  fsfc_regs_t cur;
  fsfc_regs_t next_cur;
  logic       permit;
  logic       is_exc;
  logic       undef_now;
  logic [31:0] feature_word;
  logic [31:0] exc_word;
  logic [31:0] access_word;
  logic [31:0] status_word;

  initial
  begin
    if ($bits(address) != 4)
      $error("address width unsupported");
  end

  function automatic logic [31:0] merge_be(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
      if (be[i])
        r[i*8 +: 8] = new_v[i*8 +: 8];
    return r;
  endfunction : merge_be

  ////////////////////////////////////////////////////////////////////////////
  // access gating

  assign is_exc = (address == `FSFC_OFS_EXC_CTRL);

  fsfc_access_gate u_gate
  (
    .privileged          (cur.access[`FSFC_ACC_PRIV_BIT]),
    .secure              (cur.access[`FSFC_ACC_SECURE_BIT]),
    .coproc_access_ctrl  (cur.access[`FSFC_ACC_COPROC_BIT]),
    .coproc_ten_grant    (cur.access[`FSFC_ACC_TEN_BIT]),
    .coproc_eleven_grant (cur.access[`FSFC_ACC_ELEVEN_BIT]),
    .hyp_coproc_trap     (cur.access[`FSFC_ACC_HYP_TRAP_BIT]),
    .is_exc_ctrl         (is_exc),
    .permit              (permit)
  );

  ////////////////////////////////////////////////////////////////////////////
  // register images

  always_comb
  begin
    feature_word = {`FSFC_FEAT_ROUND,
                    `FSFC_FEAT_SHORT_VEC,
                    `FSFC_FEAT_SQRT,
                    `FSFC_FEAT_DIVIDE,
                    `FSFC_FEAT_TRAP,
                    `FSFC_FEAT_DOUBLE,
                    `FSFC_FEAT_SINGLE,
                    `FSFC_FEAT_BANK};
    exc_word = `FSFC_RESET_WORD;
    exc_word[`FSFC_EXC_ASYNC_BIT] = 1'b0;
    exc_word[`FSFC_EXC_ENABLE_BIT] = cur.unit_en;
    exc_word[`FSFC_EXC_UNK_MSB:0] = cur.exc_unk;
    access_word = `FSFC_RESET_WORD;
    access_word[`FSFC_ACC_STRIDE_MSB:0] = cur.access;
    status_word = `FSFC_RESET_WORD;
    status_word[`FSFC_ST_DENIED_BIT] = cur.denied;
    status_word[`FSFC_ST_UNIT_EN_BIT] = cur.unit_en;
    status_word[`FSFC_ST_UNDEF_BIT] = cur.undef_seen;
  end

  assign undef_now = float_dp_op && !float_cmp_cvt
                     && (cur.access[`FSFC_ACC_STRIDE_MSB:`FSFC_ACC_STRIDE_LSB]
                         != 3'h0);

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    logic [31:0] merged;
    logic        ok;
    merged = `FSFC_RESET_WORD;
    ok = 1'b0;
    next_cur = cur;
    next_cur.undef_seen = undef_now;
    case (cur.state)
      FSFC_IDLE:
      begin
        if (read || write)
        begin
          next_cur.state = FSFC_ANSW;
          next_cur.waitreq = 1'b0;
          next_cur.resp_err = 1'b0;
          next_cur.rdata = `FSFC_RESET_WORD;
          ok = FLOAT_PRESENT && (permit ||
                 address == `FSFC_OFS_ACCESS_CTRL ||
                 address == `FSFC_OFS_STATUS);
          if (!ok && (address == `FSFC_OFS_FEATURE_ZERO || is_exc))
          begin
            next_cur.resp_err = 1'b1;
            next_cur.rdata = `FSFC_ERR_WORD;
            next_cur.denied = 1'b1;
          end
          else
          begin
            case (address)
              `FSFC_OFS_FEATURE_ZERO: next_cur.rdata = feature_word;
              `FSFC_OFS_EXC_CTRL:
              begin
                next_cur.rdata = exc_word;
                if (write)
                begin
                  merged = merge_be(exc_word, writedata, byteenable);
                  next_cur.unit_en = merged[`FSFC_EXC_ENABLE_BIT];
                  next_cur.exc_unk = merged[`FSFC_EXC_UNK_MSB:0];
                end
              end
              `FSFC_OFS_ACCESS_CTRL:
              begin
                next_cur.rdata = access_word;
                if (write)
                begin
                  merged = merge_be(access_word, writedata, byteenable);
                  next_cur.access = merged[`FSFC_ACC_STRIDE_MSB:0];
                end
              end
              `FSFC_OFS_STATUS:
              begin
                next_cur.rdata = status_word;
                if (write && writedata[`FSFC_ST_DENIED_BIT]
                    && byteenable[0])
                  next_cur.denied = 1'b0;
              end
              default:
              begin
                next_cur.resp_err = 1'b1;
                next_cur.rdata = `FSFC_RESET_WORD;
              end
            endcase
          end
        end
      end
      FSFC_ANSW:
      begin
        next_cur.state = FSFC_IDLE;
        next_cur.waitreq = 1'b1;
      end
      default:
      begin
        next_cur.state = FSFC_IDLE;
        next_cur.waitreq = 1'b1;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cur <= '0;
      cur.state <= FSFC_IDLE;
      cur.waitreq <= 1'b1;
      cur.unit_en <= 1'b0;
    end
    else
      cur <= next_cur;
  end

  assign readdata = cur.rdata;
  assign waitrequest = cur.waitreq;
  assign response = {cur.resp_err, 1'b0};
  assign float_unit_enable = cur.unit_en;
  assign undef_instr = cur.undef_seen;

endmodule : fsfc_regs

/* File: bench/fsfc_regs_assertions.sv */
`timescale 1ns/1ps
module fsfc_regs_chk
(
  // clock and reset
  input wire logic        clk,
  input wire logic        reset_n,
  // register bus
  input wire logic [3:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic [3:0]  byteenable,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  input wire logic [1:0]  response,
  // unit side
  input wire logic        float_dp_op,
  input wire logic        float_cmp_cvt,
  input wire logic        float_unit_enable,
  input wire logic        undef_instr
);
  logic ok;
  logic rd_ok;
  assign ok    = !waitrequest && response == 2'b00;
  assign rd_ok = read && ok;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  chk_answer_next: assert property ((read || write) && waitrequest
    |=> !waitrequest) else $error("no answer after request");
  chk_wait_pulse: assert property (!waitrequest |=> waitrequest)
    else $error("wait low too long");
  chk_feature_word: assert property (
    rd_ok && address == 4'h0 |-> readdata == 32'h1011_0222)
    else $error("feature word wrong");
  chk_ctrl_fixed: assert property (
    rd_ok && address == 4'h4 |-> !readdata[31] && readdata[29:26] == 4'h0)
    else $error("fixed control bits wrong");
  chk_enable_view: assert property (
    rd_ok && address == 4'h4 |-> readdata[30] == float_unit_enable)
    else $error("enable read mismatch");
  chk_enable_cause: assert property (
    $changed(float_unit_enable) |-> $past(write && address == 4'h4))
    else $error("enable moved without write");
  chk_refuse_word: assert property (
    read && !waitrequest && response == 2'b10
    && (address == 4'h0 || address == 4'h4)
    |-> readdata == 32'hDEAD_0000) else $error("refused data wrong");
  chk_undef_quiet: assert property (
    float_cmp_cvt || !float_dp_op |=> !undef_instr)
    else $error("undef on allowed op");
  chk_undef_src: assert property (
    undef_instr |-> $past(float_dp_op && !float_cmp_cvt))
    else $error("undef without cause");
  chk_reset_clear: assert property (
    $rose(reset_n) |-> !float_unit_enable)
    else $error("enable set after reset");
  cov_feature: cover property (rd_ok && address == 4'h0);
  cov_refused: cover property (!waitrequest && response == 2'b10);
  cov_undef: cover property (undef_instr);
endmodule : fsfc_regs_chk

bind fsfc_regs fsfc_regs_chk fsfc_regs_chk_i (.clk, .reset_n, .address,
  .read, .write, .writedata, .byteenable, .readdata, .waitrequest,
  .response, .float_dp_op, .float_cmp_cvt, .float_unit_enable,
  .undef_instr);

/* File: bench/fsfc_regs_tb_top.sv */
`timescale 1ns/1ps
module fsfc_regs_tb_top;
  localparam logic [33:0] DENY = {2'b10, 32'hDEAD_0000};
  localparam logic [33:0] FEAT = {2'b00, 32'h1011_0222};
  logic        clk, reset_n, read, write, float_dp_op, float_cmp_cvt;
  logic [3:0]  address, byteenable;
  logic [31:0] writedata, readdata;
  logic        waitrequest, float_unit_enable, undef_instr;
  logic [1:0]  response;
  logic [33:0] r;
  logic [31:0] absent_rdata;
  logic [1:0]  absent_resp;
  int          mismatches, n_checks, cycles;

  fsfc_regs fsfc_regs_i (.clk(clk), .reset_n(reset_n), .address(address),
    .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .response(response),
    .float_dp_op(float_dp_op), .float_cmp_cvt(float_cmp_cvt),
    .float_unit_enable(float_unit_enable), .undef_instr(undef_instr));

  // same bus, float unit left out
  fsfc_regs #(.FLOAT_PRESENT(1'b0)) fsfc_regs_absent_i (.clk(clk),
    .reset_n(reset_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable),
    .readdata(absent_rdata), .waitrequest(), .response(absent_resp),
    .float_dp_op(float_dp_op), .float_cmp_cvt(float_cmp_cvt),
    .float_unit_enable(), .undef_instr());

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      mismatches++;
      complete_run();
    end
  end

  task automatic chk(input logic [33:0] g, input logic [33:0] e);
    n_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  task automatic acc(input logic we, input logic [3:0] a,
                     input logic [31:0] d, output logic [33:0] q);
    @(posedge clk);
    read <= !we;
    write <= we;
    address <= a;
    writedata <= d;
    do @(posedge clk); while (waitrequest !== 1'b0);
    q = {response, readdata};
    read <= 1'b0;
    write <= 1'b0;
  endtask : acc

  task automatic gate(input logic [31:0] ctx, input logic [3:0] a,
                      input logic [33:0] e);
    acc(1'b1, 4'h8, ctx, r);
    acc(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask : gate

  task automatic op(input logic dp, input logic cc, input logic e);
    @(posedge clk);
    float_dp_op <= dp;
    float_cmp_cvt <= cc;
    @(posedge clk);
    #1 chk({33'h0, undef_instr}, {33'h0, e});
  endtask : op

  task automatic t_ctrl;
    acc(1'b1, 4'h8, 32'h07, r);
    acc(1'b1, 4'h4, 32'hFFFF_FFFF, r);
    acc(1'b0, 4'h4, 32'h0, r);
    chk(r, {2'b00, 32'h43FF_FFFF});
    chk({33'h0, float_unit_enable}, 34'h1);
    acc(1'b1, 4'h4, 32'h0, r);
    @(posedge clk);
    #1 chk({33'h0, float_unit_enable}, 34'h0);
    acc(1'b1, 4'h4, 32'h4000_0000, r);
    chk({33'h0, float_unit_enable}, 34'h1);
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    #1 chk({33'h0, float_unit_enable}, 34'h0);
  endtask : t_ctrl

  task automatic complete_run;
    if (mismatches == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : complete_run

  initial
  begin
    {reset_n, read, write, float_dp_op, float_cmp_cvt} = 5'b0;
    address = 4'h0;
    writedata = 32'h0;
    byteenable = 4'hF;
    @(posedge clk);
    #1 chk({32'h0, waitrequest, float_unit_enable}, 34'h2);
    @(posedge clk);
    reset_n <= 1'b1;
    gate(32'h06, 4'h0, DENY);
    gate(32'h07, 4'h0, FEAT);
    chk({absent_resp, absent_rdata}, DENY);
    gate(32'h1D, 4'h0, FEAT);
    gate(32'h0D, 4'h0, DENY);
    gate(32'h15, 4'h0, DENY);
    gate(32'h3D, 4'h0, DENY);
    gate(32'h03, 4'h4, DENY);
    gate(32'h07, 4'h2, {2'b10, 32'h0});
    acc(1'b0, 4'hC, 32'h0, r);
    chk(r, {2'b00, 32'h1});
    acc(1'b1, 4'hC, 32'h1, r);
    acc(1'b0, 4'hC, 32'h0, r);
    chk(r, {2'b00, 32'h0});
    t_ctrl();
    acc(1'b1, 4'h8, 32'h107, r);
    op(1'b1, 1'b0, 1'b1);
    op(1'b1, 1'b1, 1'b0);
    op(1'b0, 1'b0, 1'b0);
    acc(1'b1, 4'h8, 32'h07, r);
    op(1'b1, 1'b0, 1'b0);
    complete_run();
  end
endmodule : fsfc_regs_tb_top
